// ### core/sbos_brake_seq.sv
// Purpose: holding-brake release sequencer of a servo drive
// Assumes: APB slave, zero wait states, one 40 MHz clock
// Notes:   terminal routing only changes on reset or apply
//
// Our own choices: the register addresses and the APB register port.
`timescale 1ns/1ps
module sbos_brake_seq #(
	parameter int MS_CYCLES = sbos_pkg::MS_CYCLES
) (
	input  logic                 clk,
	input  logic                 sys_rst,
	input  logic                 psel,
	input  logic                 penable,
	input  logic                 pwrite,
	input  logic [11:0]          paddr,
	input  logic [31:0]          pwdata,
	output logic [31:0]          prdata,
	output logic                 pready,
	output logic                 pslverr,
	input  logic                 alarm,
	input  logic                 alarm_zero_ok,
	input  logic                 overtravel,
	input  logic signed [15:0]   motor_speed,
	input  logic [13:0]          motor_max_rpm,
	input  logic [5:0]           other_out,
	output logic                 brake_release_out,
	output logic                 motor_energize,
	output logic                 speed_cmd_zero,
	output sbos_pkg::sbos_stop_t stop_method,
	output sbos_pkg::sbos_post_t post_stop_state,
	output logic [5:0]           general_output_terminal
);
	import sbos_pkg::*;

	sbos_spd_if spd ();

	sbos_state_t state_q;
	sbos_state_t state_d;
	sbos_stop_t  offm_q;
	sbos_stop_t  almm_q;
	sbos_stop_t  stopm_q;
	sbos_stop_t  stopm_d;
	sbos_post_t  post_q;
	sbos_post_t  post_d;
	logic        son_q;
	logic [13:0] dly_q;
	logic [13:0] thr_q;
	logic [6:0]  to_q;
	logic [2:0]  term_q;
	logic [2:0]  term_act_q;
	logic [31:0] rdata_q;
	logic        brake_q;
	logic        ener_q;
	logic        zcmd_q;
	logic        alm_stop_q;
	logic        setup_w;
	logic        wr_w;
	logic        hit_w;
	logic [31:0] rd_w;
	logic [31:0] stat_w;
	logic [13:0] wdly_w;
	logic [13:0] wthr_w;
	logic [6:0]  wto_w;
	logic [2:0]  wterm_w;
	logic        apply_w;
	logic        stop_req_w;
	sbos_stop_t  req_m_w;
	logic        decel_w;
	logic        tmr_start_w;
	logic [13:0] tmr_load_w;
	logic        tmr_done_w;
	logic        ot_hold_w;
	logic        brake_d;
	logic        ener_d;

	// apb decode; slave answers with no wait state
	assign setup_w = psel && !penable;
	assign wr_w    = psel && penable && pwrite;
	assign hit_w   = paddr == CTRL_OFF || paddr == DELAY_OFF
		|| paddr == THR_OFF || paddr == TO_OFF
		|| paddr == TERM_OFF_A || paddr == STOP_OFF
		|| paddr == STAT_OFF;
	assign pready  = 1'b1;
	assign pslverr = psel && penable && !hit_w;
	assign prdata  = rdata_q;

	// write values clamped to the documented ranges
	assign wdly_w  = (pwdata[13:0] > DLY_MAX || pwdata[31:14] != 18'h0)
		? DLY_MAX : pwdata[13:0];
	assign wthr_w  = (pwdata[13:0] > THR_MAX || pwdata[31:14] != 18'h0)
		? THR_MAX : pwdata[13:0];
	assign wto_w   = (pwdata[31:7] != 25'h0 || pwdata[6:0] > TO_MAX)
		? TO_MAX : (pwdata[6:0] < TO_MIN) ? TO_MIN : pwdata[6:0];
	// values 7 and above read as disabled
	assign wterm_w = (pwdata[31:3] != 29'h0 || pwdata[2:0] > TERM_OFF)
		? TERM_OFF : pwdata[2:0];
	assign apply_w = wr_w && paddr == CTRL_OFF && pwdata[CTRL_APPLY_BIT];

	// status word and read mux
	assign stat_w = {22'h0, post_q, term_act_q, ener_q, brake_q, state_q};
	assign rd_w   = paddr == CTRL_OFF   ? {31'h0, son_q}
		: paddr == DELAY_OFF  ? {18'h0, dly_q}
		: paddr == THR_OFF    ? {18'h0, thr_q}
		: paddr == TO_OFF     ? {25'h0, to_q}
		: paddr == TERM_OFF_A ? {29'h0, term_q}
		: paddr == STOP_OFF   ? {28'h0, almm_q, offm_q}
		: paddr == STAT_OFF   ? stat_w : 32'h0;

	// read data captured in the setup phase, stable through access
	always_ff @(posedge clk) begin
		if (sys_rst)
			rdata_q <= 32'h0;
		else if (setup_w)
			rdata_q <= pwrite ? 32'h0 : rd_w;
	end

	// settings registers; take effect immediately
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			son_q <= 1'b0;
			dly_q <= DLY_RST;
			thr_q <= THR_RST;
			to_q  <= TO_RST;
		end else if (wr_w) begin
			if (paddr == CTRL_OFF)
				son_q <= pwdata[CTRL_SON_BIT];
			if (paddr == DELAY_OFF)
				dly_q <= wdly_w;
			if (paddr == THR_OFF)
				thr_q <= wthr_w;
			if (paddr == TO_OFF)
				to_q <= wto_w;
		end
	end

	// stop method selection, alarm default zero speed stop
	// zero speed default
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			offm_q <= OFFM_RST;
			almm_q <= ALMM_RST;
		end else if (wr_w && paddr == STOP_OFF) begin
			offm_q <= sbos_stop_t'(pwdata[STOP_OFFM_LSB +: 2]);
			almm_q <= sbos_stop_t'(pwdata[STOP_ALMM_LSB +: 2]);
		end
	end

	// terminal digit: stored now, used only after apply; reset restores TERM_RST
	// routing at restart
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			term_q     <= TERM_RST;
			term_act_q <= TERM_RST;
		end else begin
			if (wr_w && paddr == TERM_OFF_A)
				term_q <= wterm_w;
			if (apply_w)
				term_act_q <= term_q;
		end
	end

	// speed compare and timer
	assign spd.speed   = motor_speed;
	assign spd.thr     = thr_q;
	assign spd.max_rpm = motor_max_rpm;

	sbos_speed_cmp u_cmp (
		.bus (spd)
	);

	sbos_ms_timer #(
		.MS_CYCLES (MS_CYCLES)
	) u_tmr (
		.clk     (clk),
		.sys_rst (sys_rst),
		.start   (tmr_start_w),
		.load_ms (tmr_load_w),
		.done    (tmr_done_w)
	);

	// which method stops the motor; zero speed on alarm only if alarm_zero_ok allows it
	// method choice
	assign stop_req_w = alarm || !son_q;
	assign req_m_w    = (alarm && (alarm_zero_ok || !almm_q[1]))
		? almm_q : (alarm ? SM_SHORT : offm_q);
	assign decel_w    = req_m_w[1];

	// sequencer next state
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			ST_OFF: begin
				if (son_q && !alarm)
					state_d = ST_RUN;
			end
			ST_RUN: begin
				if (stop_req_w && spd.rest)
					state_d = (alarm && !decel_w) ? ST_OFF : ST_DELAY;
				else if (stop_req_w && decel_w)
					state_d = ST_DECEL;
				else if (stop_req_w)
					state_d = ST_WAIT;
			end
			ST_DELAY: begin
				if ((alarm && !alm_stop_q) || tmr_done_w)
					state_d = ST_OFF;
			end
			ST_DECEL: begin
				if (spd.rest)
					state_d = ST_DELAY;
			end
			ST_WAIT: begin
				if (spd.below || tmr_done_w)
					state_d = ST_OFF;
			end
			default: state_d = ST_OFF;
		endcase
	end

	// timer loads on entry to delay or wait
	// timeout in 10 ms units
	assign tmr_start_w = state_d != state_q
		&& (state_d == ST_DELAY || state_d == ST_WAIT);
	assign tmr_load_w  = state_d == ST_WAIT
		? 14'(to_q * TIMEOUT_UNIT_MS) : dly_q;

	// remember the method in use while stopping
	assign stopm_d = (state_q == ST_RUN && state_d != ST_RUN)
		? req_m_w : stopm_q;

	// brake and power decode from the next state
	// overtravel hold
	assign ot_hold_w = overtravel && son_q && !alarm;
	assign brake_d = state_d == ST_RUN || state_d == ST_DECEL
		|| state_d == ST_WAIT || ot_hold_w;
	assign ener_d  = state_d == ST_RUN || state_d == ST_DELAY
		|| state_d == ST_DECEL;

	// state after the stop
	// post-stop state
	always_comb begin
		post_d = PS_NONE;
		if (state_d == ST_DELAY)
			post_d = PS_ZFIX;
		else if (state_d == ST_OFF)
			post_d = ((stopm_d[1] ? offm_q : stopm_d) == SM_SHORT)
				? PS_SHORT : PS_FREE;
	end

	// sequencer and output registers
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			state_q    <= ST_OFF;
			stopm_q    <= OFFM_RST;
			post_q     <= PS_SHORT;
			brake_q    <= 1'b0;
			ener_q     <= 1'b0;
			zcmd_q     <= 1'b0;
			alm_stop_q <= 1'b0;
		end else begin
			state_q <= state_d;
			stopm_q <= stopm_d;
			post_q  <= post_d;
			brake_q <= brake_d;
			ener_q  <= ener_d;
			zcmd_q  <= state_d == ST_DECEL;
			if (state_q == ST_RUN)
				alm_stop_q <= alarm;
		end
	end

	assign brake_release_out = brake_q;
	assign motor_energize    = ener_q;
	assign speed_cmd_zero    = zcmd_q;
	assign stop_method       = stopm_q;
	assign post_stop_state   = post_q;

	// terminals: brake ORed with whatever else shares the pin
	genvar gi;
	generate
		for (gi = 0; gi < 6; gi++) begin : g_term
			assign general_output_terminal[gi] = other_out[gi]
				|| (term_act_q == 3'(gi) && brake_q);
		end
	endgenerate

	// checks
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);

	alarm_brake_a: assert property (
		alarm && state_q == ST_RUN && spd.rest |=> !brake_release_out)
		else $error("brake stayed released on alarm at rest");
	brake_level_a: assert property (
		state_q inside {ST_OFF, ST_DELAY} && !$past(ot_hold_w)
		|-> !brake_release_out)
		else $error("brake released while stopped");
	ot_hold_a: assert property (
		ot_hold_w |=> brake_release_out)
		else $error("overtravel did not hold brake released");
	term_route_a: assert property (
		brake_release_out && term_act_q < TERM_OFF
		|-> general_output_terminal[term_act_q])
		else $error("brake not on assigned terminal");
	term_or_a: assert property (
		other_out[0] |-> general_output_terminal[0])
		else $error("shared terminal lost other signal");
	off_delay_a: assert property (
		state_q == ST_RUN && !son_q && !alarm && spd.rest
		|=> !brake_release_out && motor_energize)
		else $error("servo off at rest not sequenced");
	alarm_cut_a: assert property (
		state_q == ST_DELAY && alarm && !alm_stop_q |=> !motor_energize)
		else $error("alarm did not cut motor power");
	wait_exit_a: assert property (
		state_q == ST_WAIT && (spd.below || tmr_done_w)
		|=> !brake_release_out && state_q == ST_OFF)
		else $error("brake not engaged after wait");
	decel_rest_a: assert property (
		state_q == ST_DECEL && spd.rest |=> state_q == ST_DELAY)
		else $error("zero speed stop skipped the delay");

	run_seen_c: cover property (state_q == ST_RUN ##1 state_q == ST_DELAY);
	wait_seen_c: cover property (state_q == ST_WAIT ##1 state_q == ST_OFF);
	decel_seen_c: cover property (state_q == ST_DECEL ##1 state_q == ST_DELAY);
endmodule // sbos_brake_seq

// ### core/sbos_pkg.sv
// Purpose: shared constants and types of the brake output sequencer
// Assumes: 40 MHz clock, APB register access, byte offsets
// Notes:   timing figures are kept in their own units, cycles derived
package sbos_pkg;
	// clock and millisecond tick
	localparam int CLK_PERIOD_NS   = 25;
	localparam int MS_NS           = 1000000;
	localparam int MS_CYCLES       = MS_NS / CLK_PERIOD_NS;
	localparam int TIMEOUT_UNIT_MS = 10;
	// speed at or below which the motor counts as at rest
	localparam logic [15:0] REST_RPM = 16'h0005;
	// setting limits and reset values
	localparam logic [13:0] DLY_MAX  = 14'h2710;
	localparam logic [13:0] DLY_RST  = 14'h0000;
	localparam logic [13:0] THR_MAX  = 14'h2710;
	localparam logic [13:0] THR_RST  = 14'h0064;
	localparam logic [6:0]  TO_MIN   = 7'h0A;
	localparam logic [6:0]  TO_MAX   = 7'h64;
	localparam logic [6:0]  TO_RST   = 7'h32;
	localparam logic [2:0]  TERM_RST = 3'h2;
	localparam logic [2:0]  TERM_OFF = 3'h6;
	// register byte offsets
	localparam logic [11:0] CTRL_OFF   = 12'h000;
	localparam logic [11:0] DELAY_OFF  = 12'h004;
	localparam logic [11:0] THR_OFF    = 12'h008;
	localparam logic [11:0] TO_OFF     = 12'h00C;
	localparam logic [11:0] TERM_OFF_A = 12'h010;
	localparam logic [11:0] STOP_OFF   = 12'h014;
	localparam logic [11:0] STAT_OFF   = 12'h018;
	// field positions
	localparam int CTRL_SON_BIT   = 0;
	localparam int CTRL_APPLY_BIT = 1;
	localparam int STOP_OFFM_LSB  = 0;
	localparam int STOP_ALMM_LSB  = 2;
	typedef enum logic [2:0] {
		ST_OFF   = 3'b000,
		ST_RUN   = 3'b001,
		ST_DELAY = 3'b010,
		ST_DECEL = 3'b011,
		ST_WAIT  = 3'b100
	} sbos_state_t;
	typedef enum logic [1:0] {
		SM_SHORT = 2'b00,
		SM_COAST = 2'b01,
		SM_ZERO  = 2'b10,
		SM_DECEL = 2'b11
	} sbos_stop_t;
	typedef enum logic [1:0] {
		PS_NONE  = 2'b00,
		PS_SHORT = 2'b01,
		PS_FREE  = 2'b10,
		PS_ZFIX  = 2'b11
	} sbos_post_t;
	localparam sbos_stop_t OFFM_RST = SM_SHORT;
	localparam sbos_stop_t ALMM_RST = SM_ZERO;
endpackage

// ### core/sbos_spd_if.sv
// Purpose: carries speed, limits and compare results between modules
// Assumes: one clock domain, purely combinational signals
// Notes:   user side drives inputs, compare side answers
`timescale 1ns/1ps
interface sbos_spd_if;
	logic signed [15:0] speed;
	logic        [13:0] thr;
	logic        [13:0] max_rpm;
	logic               below;
	logic               rest;
	modport cmp  (input speed, thr, max_rpm, output below, rest);
	modport user (output speed, thr, max_rpm, input below, rest);
endinterface

// ### core/sbos_speed_cmp.sv
// Purpose: speed magnitude against clamped brake threshold
// Assumes: speed in rpm, signed two's complement
// Notes:   combinational, no state
`timescale 1ns/1ps
module sbos_speed_cmp (
	sbos_spd_if.cmp bus
);
	import sbos_pkg::*;
	logic [15:0] abs_w;
	logic [13:0] eff_thr_w;

	// magnitude, either direction of rotation
	// magnitude compare
	assign abs_w = bus.speed[15] ? 16'(-bus.speed) : 16'(bus.speed);
	assign eff_thr_w = (bus.thr > bus.max_rpm) ? bus.max_rpm : bus.thr;
	assign bus.below = abs_w < {2'h0, eff_thr_w};
	assign bus.rest  = abs_w <= REST_RPM;
endmodule // sbos_speed_cmp

// ### core/sbos_ms_timer.sv
// Purpose: one-shot millisecond timer with its own tick divider
// Assumes: start is a one-cycle pulse
// Notes:   divider restarts on start so the first ms is never short
`timescale 1ns/1ps
module sbos_ms_timer #(
	parameter int MS_CYCLES = sbos_pkg::MS_CYCLES
) (
	input  logic        clk,
	input  logic        sys_rst,
	input  logic        start,
	input  logic [13:0] load_ms,
	output logic        done
);
	import sbos_pkg::*;
	logic [15:0] div_q;
	logic [13:0] cnt_q;
	logic        run_q;
	logic        done_q;
	logic        tick_w;

	// one-cycle millisecond enable
	assign tick_w = run_q && (div_q == 16'(MS_CYCLES - 1));
	assign done   = done_q;

	// divider, counter and expiry flag
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			div_q  <= 16'h0000;
			cnt_q  <= 14'h0000;
			run_q  <= 1'b0;
			done_q <= 1'b0;
		end else if (start) begin
			div_q  <= 16'h0000;
			cnt_q  <= load_ms;
			run_q  <= load_ms != 14'h0000;
			done_q <= load_ms == 14'h0000;
		end else if (tick_w) begin
			div_q  <= 16'h0000;
			cnt_q  <= cnt_q - 14'h0001;
			run_q  <= cnt_q > 14'h0001;
			done_q <= cnt_q == 14'h0001;
		end else if (run_q) begin
			div_q <= div_q + 16'h0001;
		end
	end
endmodule // sbos_ms_timer

// ### tb/sbos_motor_model.sv
// Purpose: behavioural motor and load behind the brake output
// Assumes: speed follows the set value while powered and commanded
// Notes:   unpowered or zero-commanded it sheds 50 rpm each cycle;
//          stuck models a hanging load that keeps the shaft turning
`timescale 1ns/1ps
module sbos_motor_model (
	input  wire logic               clk,
	input  wire logic               sys_rst,
	input  wire logic               energize,
	input  wire logic               cmd_zero,
	input  wire logic               stuck,
	input  wire logic signed [15:0] set_rpm,
	output logic signed [15:0]      speed
);
	// speed tracking, decay toward rest in both directions
	always_ff @(posedge clk) begin
		if (sys_rst)
			speed <= 16'sh0000;
		else if (energize && !cmd_zero)
			speed <= set_rpm;
		else if (stuck)
			speed <= speed;
		else if (speed > 16'sh0032)
			speed <= speed - 16'sh0032;
		else if (speed < -16'sh0032)
			speed <= speed + 16'sh0032;
		else
			speed <= 16'sh0000;
	end
endmodule // sbos_motor_model

// ### tb/servo_brake_output_sequencer_tb_top.sv
// Purpose: self-checking bench of the brake output sequencer
// Assumes: ms tick shortened to 10 cycles, APB zero wait states
// Notes:   every wait is bounded; a hang ends in the closing report
`timescale 1ns/1ps
module servo_brake_output_sequencer_tb_top;
	import sbos_pkg::*;
	localparam int MSC = 10;
	logic clk = 1'b0, sys_rst = 1'b1;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, q;
	logic pready, pslverr, e, brk, enz, szero, stuck = 1'b0;
	logic alarm = 1'b0, zok = 1'b0, ot = 1'b0;
	logic signed [15:0] spd, set_rpm = 16'sh0000;
	logic [13:0] maxr = 14'h2710;
	logic [5:0] other = 6'h00, term;
	sbos_stop_t smeth;
	sbos_post_t post;
	int n_fail = 0, checked = 0, n;

	// 40 MHz clock
	always #12.5 clk = ~clk;

	sbos_brake_seq #(.MS_CYCLES(MSC)) dut (.clk(clk), .sys_rst(sys_rst),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .alarm(alarm), .alarm_zero_ok(zok),
		.overtravel(ot), .motor_speed(spd), .motor_max_rpm(maxr),
		.other_out(other), .brake_release_out(brk),
		.motor_energize(enz), .speed_cmd_zero(szero),
		.stop_method(smeth), .post_stop_state(post),
		.general_output_terminal(term));

	sbos_motor_model motor (.clk(clk), .sys_rst(sys_rst),
		.energize(enz), .cmd_zero(szero), .stuck(stuck),
		.set_rpm(set_rpm), .speed(spd));

	task end_of_test;
		if (n_fail == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task chk(input string nm, input logic [31:0] x, input logic [31:0] g);
		checked++;
		if (g !== x) begin
			$display("MISMATCH %s exp %0h got %0h", nm, x, g);
			n_fail++;
		end
	endtask

	// one APB transfer; request held until pready is seen high
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge clk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (pready !== 1'b1) begin
			chk("pready", 1, pready);
			end_of_test();
		end else begin
			q = prdata;
			e = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask

	task rd(input logic [11:0] a, input logic [31:0] x, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		chk(nm, x, q);
	endtask

	// waits for brake (s=0) or energize (s=1) to reach v
	task wt(input int s, input logic v, input int lim, output int k);
		logic c;
		k = 0;
		do begin
			@(posedge clk);
			#1;
			k++;
			c = (s == 0) ? brk : enz;
		end while (c !== v && k < lim);
		if (c !== v) begin
			chk("wait", v, c);
			end_of_test();
		end
	endtask

	task t_regs;
		rd(THR_OFF, 32'h0000_0064, "thr");
		rd(TO_OFF, 32'h0000_0032, "to");
		rd(TERM_OFF_A, 32'h0000_0002, "term");
		rd(STOP_OFF, 32'h0000_0008, "stop");
		rd(12'h040, 32'h0000_0000, "unmapped");
		chk("slverr", 1, e);
		chk("brk_rst", 0, brk);
	endtask

	// brake follows the configured terminal after apply; other signal stays on terminal 0
	task t_route;
		other <= 6'h01;
		apb(1'b1, CTRL_OFF, 32'h0000_0001);
		wt(0, 1'b1, 5, n);
		chk("term2", 6'h05, term);
		apb(1'b1, TERM_OFF_A, 32'h0000_0004);
		@(posedge clk);
		#1;
		chk("pending", 6'h05, term);
		apb(1'b1, CTRL_OFF, 32'h0000_0003);
		repeat (2) @(posedge clk);
		#1;
		chk("term4", 6'h11, term);
		apb(1'b1, TERM_OFF_A, 32'h0000_0007);
		rd(TERM_OFF_A, 32'h0000_0006, "term_clamp");
		apb(1'b1, CTRL_OFF, 32'h0000_0003);
		repeat (2) @(posedge clk);
		#1;
		chk("term_off", 6'h01, term);
		@(posedge clk);
		ot <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("ot_brk", 1, brk);
		@(posedge clk);
		ot <= 1'b0;
	endtask

	task t_off_rest;
		apb(1'b1, DELAY_OFF, 32'h0000_0003);
		apb(1'b1, CTRL_OFF, 32'h0000_0000);
		@(posedge clk);
		#1;
		chk("off_brk", 0, brk);
		chk("off_enz", 1, enz);
		chk("off_post", PS_ZFIX, post);
		wt(1, 1'b0, 35, n);
		chk("off_dly", 1, n > 28 && n < 33);
		chk("off_meth", SM_SHORT, smeth);
		chk("off_post2", PS_SHORT, post);
	endtask

	task t_alarm_spin;
		apb(1'b1, STOP_OFF, 32'h0000_0000);
		apb(1'b1, THR_OFF, 32'h0000_2710);
		rd(THR_OFF, 32'h0000_2710, "thr_max");
		maxr <= 14'h03E8;
		set_rpm <= -16'sh0BB8;
		apb(1'b1, CTRL_OFF, 32'h0000_0001);
		repeat (4) @(posedge clk);
		alarm <= 1'b1;
		wt(1, 1'b0, 2, n);
		chk("spin_brk", 1, brk);
		wt(0, 1'b0, 80, n);
		chk("spin_spd", 1, spd > -16'sh03E8 && spd <= -16'sh0352);
		chk("spin_post", PS_SHORT, post);
		@(posedge clk);
		alarm <= 1'b0;
	endtask

	// alarm with coasting stop and a load that keeps turning
	task t_alarm_to;
		apb(1'b1, TO_OFF, 32'h0000_0005);
		rd(TO_OFF, 32'h0000_000A, "to_min");
		apb(1'b1, STOP_OFF, 32'h0000_0004);
		set_rpm <= 16'sh0BB8;
		stuck <= 1'b1;
		wt(1, 1'b1, 10, n);
		repeat (4) @(posedge clk);
		alarm <= 1'b1;
		wt(1, 1'b0, 2, n);
		repeat (990) @(posedge clk);
		#1;
		chk("to_early", 1, brk);
		wt(0, 1'b0, 15, n);
		chk("to_meth", SM_COAST, smeth);
		chk("to_post", PS_FREE, post);
		@(posedge clk);
		alarm <= 1'b0;
		stuck <= 1'b0;
	endtask

	// zero speed stop; overtravel later holds the brake in the delay
	task t_zero;
		apb(1'b1, STOP_OFF, 32'h0000_0008);
		zok <= 1'b1;
		wt(1, 1'b1, 10, n);
		repeat (4) @(posedge clk);
		alarm <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("z_cmd", 1, szero);
		chk("z_meth", SM_ZERO, smeth);
		chk("z_enz", 1, enz);
		chk("z_brk", 1, brk);
		wt(0, 1'b0, 80, n);
		chk("z_spd", 0, spd);
		chk("z_post", PS_ZFIX, post);
		@(posedge clk);
		alarm <= 1'b0;
		ot <= 1'b1;
		@(posedge clk);
		#1;
		chk("z_ot", 1, brk);
		wt(1, 1'b0, 35, n);
		chk("z_dly", 1, n > 28 && n < 33);
	endtask

	// reset, then the scenarios in turn
	initial begin
		repeat (6) @(posedge clk);
		sys_rst <= 1'b0;
		t_regs();
		t_route();
		t_off_rest();
		t_alarm_spin();
		t_alarm_to();
		t_zero();
		end_of_test();
	end
endmodule // servo_brake_output_sequencer_tb_top
